// *** rtl/psw_pin_strap_wake.sv ***
// strap capture, reset fallback, wake request, write gate and eeprom pin mux
// assumes an apb master on clk, an eeprom engine and phy logic on the same clk,
// and pins (reset, straps, host strobes, mii monitor taps) asynchronous to clk
module psw_pin_strap_wake
    import psw_pkg::*;
(
    input  wire  logic         clk,
    input  wire  logic         arst_n,
    input  wire  psw_apb_req_s apbReq,
    output       psw_apb_rsp_s apbRsp,
    input  wire  logic         hwResetLow,
    input  wire  logic         crossoverAutoStrap,
    input  wire  logic         speedStrap,
    input  wire  logic         chipSelLow,
    input  wire  logic         writeStrobeLow,
    input  wire  logic         cableReversed,
    input  wire  logic         wakeEvent,
    input  wire  psw_mii_mon_s miiMon,
    input  wire  psw_ee_ctl_s  eeCtl,
    output       logic         eeCtlDataIn,
    input  wire  logic         eepromSerialDataPinIn,
    output       logic         eepromSerialDataPinOut,
    output       logic         eepromSerialDataPinOe,
    output       logic         eepromSerialClockOut,
    output       logic         eepromSelectOut,
    output       logic         pairSwap,
    output       logic         wakeRequestOut,
    output       logic         wakeRequestOe,
    output       logic         irq,
    output       psw_link_s    linkDefaults,
    output       logic         crossoverAutoEn,
    output       logic         sleeping
);

    function automatic logic muxPin(input logic [1:0] mode, input logic ee,
                                    input logic gpo, input logic monA, input logic monB);
        case (mode)
            PM_EEPROM: muxPin = ee;
            PM_GPO:    muxPin = gpo;
            PM_MON_A:  muxPin = monA;
            PM_MON_B:  muxPin = monB;
            default:   muxPin = ee;
        endcase
    endfunction : muxPin

    // input synchronisers: three stages, a change counts when stages two and three agree
    logic [SYNC_W-1:0] syncIn;
    logic [SYNC_W-1:0] s1_q;
    logic [SYNC_W-1:0] s2_q;
    logic [SYNC_W-1:0] s3_q;
    logic [SYNC_W-1:0] filt_q;

    assign syncIn = {miiMon.rxClk, miiMon.rxDv, miiMon.txClk, miiMon.txEn,
                     eepromSerialDataPinIn, writeStrobeLow, chipSelLow,
                     speedStrap, crossoverAutoStrap, hwResetLow};

    genvar g;
    generate
        for (g = 0; g < SYNC_W; g++) begin : gSync
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    s1_q[g]   <= SYNC_INIT[g];
                    s2_q[g]   <= SYNC_INIT[g];
                    s3_q[g]   <= SYNC_INIT[g];
                    filt_q[g] <= SYNC_INIT[g];
                end else begin
                    s1_q[g] <= syncIn[g];
                    s2_q[g] <= s1_q[g];
                    s3_q[g] <= s2_q[g];
                    if (s2_q[g] == s3_q[g]) begin
                        filt_q[g] <= s3_q[g];
                    end
                end
            end
        end
    endgenerate

    // internal reset: power-on timer, then the filtered reset pin
    logic [POR_CNT_W-1:0] porCnt_q;
    logic                 intRst;
    logic                 rstPrev_q;
    logic                 relEdge;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            porCnt_q <= POR_CNT_INIT;
        end else if (porCnt_q != '0) begin
            porCnt_q <= porCnt_q - POR_CNT_W'(1);
        end
    end

    // a floating pin reads high through its pull-up, so only the timer resets
    assign intRst  = (porCnt_q != '0) | ~filt_q[SI_HWRST];
    assign relEdge = rstPrev_q & ~intRst;

    // straps: caught on the first cycle out of reset, kept until the next reset
    logic speedLatched_q;
    logic autoXLatched_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rstPrev_q      <= 1'b1;
            speedLatched_q <= 1'b1;
            autoXLatched_q <= 1'b0;
        end else begin
            rstPrev_q <= intRst;
            if (relEdge) begin
                speedLatched_q <= filt_q[SI_SPEED];
                autoXLatched_q <= filt_q[SI_AUTO_X];
            end
        end
    end

    // apb slave: pready one cycle after setup, so every access takes two cycles
    logic              pready_q;
    logic              pslverr_q;
    logic [31:0]       prdata_q;
    logic              setupPh;
    logic              accPh;
    logic              selPinCfg;
    logic              selPwrCtl;
    logic              selStatus;
    logic              selIrqStat;
    logic              selIrqEn;
    logic              selIrqClr;
    logic              selOrder;
    logic              mapped;
    logic [31:0]       rdMux;
    logic              accWr;
    logic              wrTaken;
    logic              wrDropped;
    logic              rdDone;

    logic [PC_W-1:0]   pinCfg_q;
    logic [PW_W-1:0]   pwrCtl_q;
    logic [IRQ_W-1:0]  irqStat_q;
    logic [IRQ_W-1:0]  irqEn_q;
    logic [IRQ_W-1:0]  irqStat_d;
    logic [IRQ_W-1:0]  irqClr;
    logic [IRQ_W-1:0]  irqEv;
    logic              sleep_q;
    logic              wrOpen_q;
    logic              wakePend_q;
    logic              hostWrPrev_q;
    logic              hostWrPin;
    logic              hostWrStart;
    logic              wakeExit;
    logic              wakeSeen;
    logic              sleepReq;

    assign setupPh    = apbReq.psel & ~apbReq.penable;
    assign accPh      = apbReq.psel & apbReq.penable & pready_q;
    assign selPinCfg  = apbReq.paddr == OFS_PIN_CFG;
    assign selPwrCtl  = apbReq.paddr == OFS_PWR_CTL;
    assign selStatus  = apbReq.paddr == OFS_STATUS;
    assign selIrqStat = apbReq.paddr == OFS_IRQ_STAT;
    assign selIrqEn   = apbReq.paddr == OFS_IRQ_EN;
    assign selIrqClr  = apbReq.paddr == OFS_IRQ_CLR;
    assign selOrder   = apbReq.paddr == OFS_ORDER_TEST;
    assign mapped     = selPinCfg | selPwrCtl | selStatus | selIrqStat | selIrqEn
                      | selIrqClr | selOrder;

    assign rdMux = selPinCfg  ? {25'h0, pinCfg_q} :
                   selPwrCtl  ? {28'h0, sleep_q, pwrCtl_q} :
                   selStatus  ? {26'h0, wakePend_q, pairSwap, autoXLatched_q,
                                 speedLatched_q, wrOpen_q, sleep_q} :
                   selIrqStat ? {29'h0, irqStat_q} :
                   selIrqEn   ? {29'h0, irqEn_q} :
                   selOrder   ? ORDER_TEST_VAL : 32'h0000_0000;

    assign accWr     = accPh & apbReq.pwrite & ~pslverr_q;
    assign wrTaken   = accWr & wrOpen_q;
    assign wrDropped = accWr & ~wrOpen_q;
    assign rdDone    = accPh & ~apbReq.pwrite;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= setupPh;
            pslverr_q <= setupPh & ~mapped;
            prdata_q  <= (setupPh & ~apbReq.pwrite) ? rdMux : 32'h0000_0000;
        end
    end

    assign apbRsp = '{prdata: prdata_q, pready: pready_q, pslverr: pslverr_q};

    // host write cycle on the pins: chip select and write strobe both low
    assign hostWrPin   = ~filt_q[SI_CS] & ~filt_q[SI_WR];
    assign hostWrStart = hostWrPin & ~hostWrPrev_q;
    assign wakeExit    = sleep_q & hostWrStart;
    assign wakeSeen    = wakeEvent & pwrCtl_q[PW_WAKE_EN];
    assign sleepReq    = wrTaken & selPwrCtl & apbReq.pwdata[PW_SLEEP];

    assign irqClr    = (wrTaken & selIrqClr) ? apbReq.pwdata[IRQ_W-1:0] : IRQ_RST;
    assign irqEv     = {wrDropped, wakeExit, wakeSeen};
    // a new event beats a clear in the same cycle
    assign irqStat_d = (irqStat_q & ~irqClr) | irqEv;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pinCfg_q     <= PIN_CFG_RST;
            pwrCtl_q     <= PWR_CTL_RST;
            irqStat_q    <= IRQ_RST;
            irqEn_q      <= IRQ_RST;
            sleep_q      <= 1'b0;
            wrOpen_q     <= 1'b0;
            wakePend_q   <= 1'b0;
            hostWrPrev_q <= 1'b0;
        end else if (intRst) begin
            pinCfg_q     <= PIN_CFG_RST;
            pwrCtl_q     <= PWR_CTL_RST;
            irqStat_q    <= IRQ_RST;
            irqEn_q      <= IRQ_RST;
            sleep_q      <= 1'b0;
            wrOpen_q     <= 1'b0;
            wakePend_q   <= 1'b0;
            hostWrPrev_q <= hostWrPin;
        end else begin
            hostWrPrev_q <= hostWrPin;
            irqStat_q    <= irqStat_d;
            if (wrTaken && selPinCfg) begin
                pinCfg_q <= apbReq.pwdata[PC_W-1:0];
            end
            if (wrTaken && selPwrCtl) begin
                pwrCtl_q <= apbReq.pwdata[PW_W-1:0];
            end
            if (wrTaken && selIrqEn) begin
                irqEn_q <= apbReq.pwdata[IRQ_W-1:0];
            end
            // a wake event never touches sleep; only a pin write cycle or the internal reset ends it
            if (wakeExit) begin
                sleep_q <= 1'b0;
            end else if (sleepReq) begin
                sleep_q <= 1'b1;
            end
            // leaving sleep closes writes again; that outranks a read finishing
            if (wakeExit || sleepReq) begin
                wrOpen_q <= 1'b0;
            end else if (rdDone) begin
                wrOpen_q <= 1'b1;
            end
            if (wakeSeen) begin
                wakePend_q <= 1'b1;
            end else if (wakeExit || !pwrCtl_q[PW_WAKE_EN]) begin
                wakePend_q <= 1'b0;
            end
        end
    end

    // wake request pin: open drain only ever pulls low
    logic wakeLevel;
    logic wakeOut_q;
    logic wakeOe_q;
    logic irq_q;

    assign wakeLevel = pwrCtl_q[PW_WAKE_POL] ? wakePend_q : ~wakePend_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wakeOut_q <= 1'b0;
            wakeOe_q  <= 1'b0;
            irq_q     <= 1'b0;
        end else begin
            wakeOut_q <= pwrCtl_q[PW_WAKE_OD] ? 1'b0 : wakeLevel;
            wakeOe_q  <= pwrCtl_q[PW_WAKE_OD] ? ~wakeLevel : 1'b1;
            irq_q     <= |(irqStat_d & irqEn_q);
        end
    end

    assign wakeRequestOut = wakeOut_q;
    assign wakeRequestOe  = wakeOe_q;
    assign irq            = irq_q;

    // eeprom pin mux; clock monitors are sampled at clk, so a 25 MHz tap aliases
    logic [1:0] dMode;
    logic [1:0] cMode;
    logic       altActive;
    logic       dataOutD;
    logic       dataOeD;
    logic       clkOutD;
    logic       eeDataOut_q;
    logic       eeDataOe_q;
    logic       eeClkOut_q;
    logic       eeSel_q;
    logic       eeDataIn_q;
    logic       swap_q;
    psw_link_s  link_q;
    psw_link_s  linkD;

    assign dMode     = pinCfg_q[PC_DATA_LSB +: 2];
    assign cMode     = pinCfg_q[PC_CLK_LSB +: 2];
    assign altActive = (dMode != PM_EEPROM) | (cMode != PM_EEPROM);
    assign dataOutD  = muxPin(dMode, eeCtl.dataOut, pinCfg_q[PC_GENERAL_OUTPUT_THREE],
                              filt_q[SI_TX_EN], filt_q[SI_TX_CLK]);
    // alternate roles always drive; the pin is never an input there
    assign dataOeD   = (dMode == PM_EEPROM) ? eeCtl.dataOe : 1'b1;
    assign clkOutD   = muxPin(cMode, eeCtl.clkOut, pinCfg_q[PC_GENERAL_OUTPUT_FOUR],
                              filt_q[SI_RX_DV], filt_q[SI_RX_CLK]);
    assign linkD     = '{speed100: speedLatched_q, fullDuplex: 1'b0,
                         autoNeg: speedLatched_q};

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            eeDataOut_q <= 1'b0;
            eeDataOe_q  <= 1'b0;
            eeClkOut_q  <= 1'b0;
            eeSel_q     <= 1'b0;
            eeDataIn_q  <= 1'b0;
            swap_q      <= 1'b0;
            // matches the strap register's reset; after release it trails the captured speed strap by one cycle
            link_q      <= '{speed100: 1'b1, fullDuplex: 1'b0, autoNeg: 1'b1};
        end else begin
            eeDataOut_q <= dataOutD;
            eeDataOe_q  <= dataOeD;
            eeClkOut_q  <= clkOutD;
            eeSel_q     <= altActive ? 1'b0 : eeCtl.sel;
            eeDataIn_q  <= (dMode == PM_EEPROM) ? filt_q[SI_EE_DATA] : 1'b0;
            swap_q      <= (autoXLatched_q & cableReversed) | pinCfg_q[PC_MAN_REV];
            link_q      <= linkD;
        end
    end

    assign eepromSerialDataPinOut = eeDataOut_q;
    assign eepromSerialDataPinOe  = eeDataOe_q;
    assign eepromSerialClockOut   = eeClkOut_q;
    assign eepromSelectOut        = eeSel_q;
    assign eeCtlDataIn            = eeDataIn_q;
    assign pairSwap               = swap_q;
    assign linkDefaults           = link_q;
    assign crossoverAutoEn        = autoXLatched_q;
    assign sleeping               = sleep_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    chk_sel_held_low: assert property ($past(altActive) |-> !eepromSelectOut)
        else $error("eeprom select active while a pin is in an alternate role");
    chk_general_output_three_drive: assert property (dMode == PM_GPO |=>
        eepromSerialDataPinOe && eepromSerialDataPinOut == $past(pinCfg_q[PC_GENERAL_OUTPUT_THREE]))
        else $error("data pin does not drive the gpo three value");
    chk_general_output_four_drive: assert property (cMode == PM_GPO |=>
        eepromSerialClockOut == $past(pinCfg_q[PC_GENERAL_OUTPUT_FOUR]))
        else $error("clock pin does not drive the gpo four value");
    chk_swap_follow: assert property (!intRst |=>
        pairSwap == ($past(autoXLatched_q & cableReversed) | $past(pinCfg_q[PC_MAN_REV])))
        else $error("pair swap does not follow reversal state");
    chk_write_gate: assert property (wrDropped |=>
        $stable(pinCfg_q) && $stable(pwrCtl_q) && $stable(irqEn_q))
        else $error("write took effect before any read");
    chk_wake_no_exit: assert property (sleep_q && !hostWrStart && !intRst |=> sleep_q)
        else $error("sleep left without a host write cycle");
    chk_exit_on_write: assert property (sleep_q && hostWrStart && !intRst
        |=> !sleep_q && !wrOpen_q)
        else $error("host write cycle did not end sleep");
    chk_wake_level: assert property (wakeSeen && !pwrCtl_q[PW_WAKE_OD] && !sleep_q && !intRst
        ##1 $stable(pwrCtl_q) && !sleep_q && !intRst
        |=> wakeRequestOe && wakeRequestOut == $past(pwrCtl_q[PW_WAKE_POL]))
        else $error("wake request not driven at its programmed level");
    chk_strap_latch: assert property (relEdge |=>
        speedLatched_q == $past(filt_q[SI_SPEED]) && crossoverAutoEn == $past(filt_q[SI_AUTO_X]))
        else $error("straps not captured at reset release");
    chk_reset_state: assert property (intRst |=>
        pinCfg_q == PIN_CFG_RST && !sleep_q && !wrOpen_q && irqStat_q == IRQ_RST)
        else $error("hardware reset left state behind");
    chk_link_defaults: assert property (!relEdge ##1 !relEdge |->
        linkDefaults.speed100 == speedLatched_q && linkDefaults.autoNeg == speedLatched_q
        && !linkDefaults.fullDuplex)
        else $error("link defaults disagree with speed strap");

    cov_sleep_exit: cover property (sleep_q ##1 wakeExit);
    cov_dropped_write: cover property (wrDropped);
    cov_gpo_mode: cover property (dMode == PM_GPO && cMode == PM_MON_B);
    cov_reset_release: cover property (relEdge ##[1:20] rdDone);

endmodule : psw_pin_strap_wake

// *** rtl/psw_pkg.sv ***
// constants, modes and carriers for the strap, wake and eeprom pin block
// assumes one 50 MHz clock and an apb master with 8-bit byte addresses
package psw_pkg;

    // clock and power-on timing
    localparam int          CLK_PERIOD_NS  = 20;
    localparam int          POR_TIME_NS    = 2000;
    localparam int          POR_CYCLES     = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          POR_CNT_W      = 7;
    localparam logic [6:0]  POR_CNT_INIT   = 7'(POR_CYCLES);

    // register byte offsets
    localparam int          ADDR_W         = 8;
    localparam logic [7:0]  OFS_PIN_CFG    = 8'h00;
    localparam logic [7:0]  OFS_PWR_CTL    = 8'h04;
    localparam logic [7:0]  OFS_STATUS     = 8'h08;
    localparam logic [7:0]  OFS_IRQ_STAT   = 8'h0C;
    localparam logic [7:0]  OFS_IRQ_EN     = 8'h10;
    localparam logic [7:0]  OFS_IRQ_CLR    = 8'h14;
    localparam logic [7:0]  OFS_ORDER_TEST = 8'h18;

    // pin configuration fields
    localparam int          PC_W           = 7;
    localparam int          PC_DATA_LSB    = 0;
    localparam int          PC_CLK_LSB     = 2;
    localparam int          PC_GENERAL_OUTPUT_THREE        = 4;
    localparam int          PC_GENERAL_OUTPUT_FOUR        = 5;
    localparam int          PC_MAN_REV     = 6;
    localparam logic [6:0]  PIN_CFG_RST    = 7'h00;

    // power control fields
    localparam int          PW_W           = 3;
    localparam int          PW_WAKE_EN     = 0;
    localparam int          PW_WAKE_POL    = 1;
    localparam int          PW_WAKE_OD     = 2;
    localparam int          PW_SLEEP       = 3;
    localparam logic [2:0]  PWR_CTL_RST    = 3'h0;

    // status fields
    localparam int          ST_SLEEP       = 0;
    localparam int          ST_WR_OPEN     = 1;
    localparam int          ST_SPEED       = 2;
    localparam int          ST_AUTO_X      = 3;
    localparam int          ST_SWAP        = 4;
    localparam int          ST_WAKE        = 5;

    // interrupt events
    localparam int          IRQ_W          = 3;
    localparam int          IRQ_WAKE       = 0;
    localparam int          IRQ_EXIT       = 1;
    localparam int          IRQ_DROP       = 2;
    localparam logic [2:0]  IRQ_RST        = 3'h0;

    // arbitrary value, lets software check byte order
    localparam logic [31:0] ORDER_TEST_VAL = 32'h1357_9BDF;

    // synchroniser lanes
    localparam int          SYNC_W         = 10;
    localparam int          SI_HWRST       = 0;
    localparam int          SI_AUTO_X      = 1;
    localparam int          SI_SPEED       = 2;
    localparam int          SI_CS          = 3;
    localparam int          SI_WR          = 4;
    localparam int          SI_EE_DATA     = 5;
    localparam int          SI_TX_EN       = 6;
    localparam int          SI_TX_CLK      = 7;
    localparam int          SI_RX_DV       = 8;
    localparam int          SI_RX_CLK      = 9;
    localparam logic [9:0]  SYNC_INIT      = 10'h019;

    typedef enum logic [1:0] {
        PM_EEPROM = 2'b00,
        PM_GPO    = 2'b01,
        PM_MON_A  = 2'b10,
        PM_MON_B  = 2'b11
    } psw_pin_mode_e;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [7:0]        paddr;
        logic [31:0]       pwdata;
    } psw_apb_req_s;

    typedef struct packed {
        logic [31:0]       prdata;
        logic              pready;
        logic              pslverr;
    } psw_apb_rsp_s;

    typedef struct packed {
        logic              dataOut;
        logic              dataOe;
        logic              clkOut;
        logic              sel;
    } psw_ee_ctl_s;

    typedef struct packed {
        logic              txEn;
        logic              txClk;
        logic              rxDv;
        logic              rxClk;
    } psw_mii_mon_s;

    typedef struct packed {
        logic              speed100;
        logic              fullDuplex;
        logic              autoNeg;
    } psw_link_s;

endpackage : psw_pkg

// *** sim/psw_host_model.sv ***
// host strobe pins and the serial eeprom data line outside the block
// assumes the bench raises go for as long as one host write cycle lasts
module psw_host_model
    import psw_pkg::*;
(
    input  wire logic clk,
    input  wire logic go,
    input  wire logic dataOut,
    input  wire logic dataOe,
    output      logic csLow,
    output      logic wrLow,
    output      logic dataIn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic lastQ = 1'h0;
    // both strobes low together make one host write cycle
    assign csLow  = ~go;
    assign wrLow  = ~go;
    // a released line shows the inverse of its last value, never a held copy
    assign dataIn = dataOe ? dataOut : ~lastQ;
    always_ff @(posedge clk) begin
        if (dataOe) lastQ <= dataOut;
    end
endmodule : psw_host_model

// *** sim/psw_pin_strap_wake_tb_top.sv ***
// random and corner tests for the strap, wake and eeprom pin block
// assumes the host pin model and one 50 MHz clock
module psw_pin_strap_wake_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import psw_pkg::*;
    logic         clk = 1'h0, arst_n = 1'h0, wev = 1'h0, cab = 1'h0;
    logic         hwr = 1'h1, xs = 1'h1, sp = 1'h1, hostGo = 1'h0;
    psw_apb_req_s req = '0;
    psw_apb_rsp_s rsp;
    psw_mii_mon_s mon = '0;
    psw_ee_ctl_s  ee = '0;
    psw_link_s    lnk;
    logic         csL, wrL, eIn, eOut, eOe, eClk, eSel, swp, wOut, wOe, irq, xEn, slp, dIn, er;
    logic [31:0]  rd;
    logic [1:0]   g;
    int           failures = 0, n_tests = 0, seed = 63;

    psw_pin_strap_wake uut (
        .clk(clk), .arst_n(arst_n), .apbReq(req), .apbRsp(rsp), .hwResetLow(hwr),
        .crossoverAutoStrap(xs), .speedStrap(sp), .chipSelLow(csL), .writeStrobeLow(wrL),
        .cableReversed(cab), .wakeEvent(wev), .miiMon(mon), .eeCtl(ee), .eeCtlDataIn(dIn),
        .eepromSerialDataPinIn(eIn), .eepromSerialDataPinOut(eOut),
        .eepromSerialDataPinOe(eOe), .eepromSerialClockOut(eClk), .eepromSelectOut(eSel),
        .pairSwap(swp), .wakeRequestOut(wOut), .wakeRequestOe(wOe), .irq(irq),
        .linkDefaults(lnk), .crossoverAutoEn(xEn), .sleeping(slp));
    psw_host_model host (.clk(clk), .go(hostGo), .dataOut(eOut), .dataOe(eOe),
        .csLow(csL), .wrLow(wrL), .dataIn(eIn));

    always #10 clk = ~clk;

    function automatic psw_link_s expLink(input logic s);
        return '{s, 1'h0, s};
    endfunction : expLink
    function automatic logic expMux(input logic [1:0] m, input logic gp, a, b);
        return (m == 2'h1) ? gp : (m == 2'h2) ? a : b;
    endfunction : expMux
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask : done
    // request stands until pready is seen high at a rising edge; the answer is taken there
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{1'h1, 1'h0, w, a, d};
        @(posedge clk);
        req.penable <= 1'h1;
        do begin
            @(posedge clk);
        end while (rsp.pready !== 1'h1);
        rd = rsp.prdata;
        er = rsp.pslverr;
        req <= '0;
    endtask : apb
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        check(rd, exp);
    endtask : rdchk
    task automatic pulse();
        wev <= 1'h1;
        tick(1);
        wev <= 1'h0;
        tick(4);
    endtask : pulse
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        close_out();
    end

    initial begin
        ee <= 4'($random(seed)) | 4'h4;
        mon <= 4'($random(seed));
        tick(10);
        arst_n <= 1'h1;
        tick(130);
        check(lnk, expLink(1'h1));
        check(xEn, 1'h1);
        check(eOut, ee.dataOut);
        check(dIn, ee.dataOut);
        check(eOe, ee.dataOe);
        check(eClk, ee.clkOut);
        check(eSel, ee.sel);
        done("straps");
        apb(1'h1, OFS_PIN_CFG, 32'h50);
        rdchk(OFS_PIN_CFG, 32'h0);
        apb(1'h1, OFS_PIN_CFG, 32'h40);
        tick(2);
        check(swp, 1'h1);
        for (int m = 1; m < 4; m++) begin
            g = 2'($random(seed));
            apb(1'h1, OFS_PIN_CFG, {26'h0, g, 2'(m), 2'(m)});
            tick(8);
            check(eSel, 1'h0);
            check(eOut, expMux(2'(m), g[0], mon.txEn, mon.txClk));
            check(eClk, expMux(2'(m), g[1], mon.rxDv, mon.rxClk));
            check(dIn, 1'h0);
            check(eOe, 1'h1);
            check(swp, 1'h0);
        end
        cab <= 1'h1;
        tick(3);
        check(swp, 1'h1);
        done("pin roles");
        apb(1'h1, OFS_IRQ_EN, 32'h1);
        apb(1'h1, OFS_PWR_CTL, 32'hB);
        pulse();
        check(wOut, 1'h1);
        check(slp, 1'h1);
        check(irq, 1'h1);
        rdchk(OFS_IRQ_STAT, 32'h5);
        apb(1'h1, OFS_IRQ_CLR, 32'h7);
        tick(3);
        check(irq, 1'h0);
        apb(1'h1, OFS_ORDER_TEST, 32'h0);
        check(slp, 1'h1);
        hostGo <= 1'h1;
        tick(8);
        hostGo <= 1'h0;
        tick(3);
        check(slp, 1'h0);
        check(wOut, 1'h0);
        rdchk(OFS_ORDER_TEST, ORDER_TEST_VAL);
        apb(1'h1, OFS_PWR_CTL, 32'h3);
        pulse();
        check(wOut, 1'h1);
        check(wOe, 1'h1);
        apb(1'h1, OFS_PWR_CTL, 32'h0);
        apb(1'h1, OFS_PWR_CTL, 32'h5);
        tick(2);
        check(wOe, 1'h0);
        pulse();
        check(wOe, 1'h1);
        check(wOut, 1'h0);
        apb(1'h0, 8'h1C, 32'h0);
        check(er, 1'h1);
        done("wake");
        apb(1'h1, OFS_PIN_CFG, 32'h40);
        {sp, xs, hwr} <= 3'h0;
        tick(10);
        hwr <= 1'h1;
        tick(12);
        check(lnk, expLink(1'h0));
        check(xEn, 1'h0);
        rdchk(OFS_PIN_CFG, 32'h0);
        done("hardware reset");
        close_out();
    end
endmodule : psw_pin_strap_wake_tb_top
